// File: include/isx_pkg.sv
// Constants and types for the SMBus extension of the two-wire controller
package isx_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] EXT_CTRL_OFS = 8'h00;
  localparam logic [7:0] SMB_CS_OFS = 8'h04;
  localparam logic [7:0] SECOND_ADDR_OFS = 8'h08;
  localparam logic [7:0] SLT_HIGH_OFS = 8'h0C;
  localparam logic [7:0] SLT_LOW_OFS = 8'h10;
  localparam logic [7:0] OWN_ADDR_OFS = 8'h14;
  localparam logic [7:0] ACK_CTRL_OFS = 8'h18;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h1C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
  localparam logic [7:0] RX_DATA_OFS = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GEN_CALL_BIT = 7;
  localparam int ADDR_EXT_BIT = 6;
  localparam int UPPER_MSB = 2;
  localparam int FAST_ACK_BIT = 7;
  localparam int ALERT_EN_BIT = 6;
  localparam int SECOND_EN_BIT = 5;
  localparam int TCK_SEL_BIT = 4;
  localparam int LOW_TO_BIT = 3;
  localparam int HIGH_TO_BIT = 2;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_BYTE = 1;
  localparam int IRQ_LOW = 2;
  localparam int IRQ_HIGH = 3;

  // ----------------------------------------------------------------
  // Reset values, masks and bus addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;
  localparam logic [7:0] EXT_CTRL_MASK = 8'hC7;
  localparam logic [3:0] SMB_CFG_RST = 4'h0;
  localparam logic [6:0] ADDR7_RST = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [15:0] LOW_VALUE_OFF = 16'h0000;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [6:0] ALERT_ADDR = 7'h0C;
  localparam logic [4:0] TEN_BIT_TAG = 5'h1E;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [5:0] PRESCALE_LAST = 6'h3F;
  localparam int HIGH_DIV_SHIFT = 9;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR2, ST_DATA, ST_ACK, ST_HOLD, ST_SKIP} isx_state_type;

endpackage : isx_pkg

// File: src/isx_sync.sv
// Two-flop synchroniser for the SCL and SDA pins
`timescale 1ns/1ps
module isx_sync
  import isx_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] pinIn,
  output logic [1:0] pinOut
);

  logic [1:0] stage1;

  // Idle bus reads high, so both stages reset to one
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stage1 <= 2'h3;
      pinOut <= 2'h3;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end

endmodule : isx_sync

// File: src/isx_timeout.sv
// SCL low and bus high timeout counters
`timescale 1ns/1ps
module isx_timeout
  import isx_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sclHigh,
  input wire logic busHigh,
  input wire logic timeout_clock_select,
  input wire logic [15:0] low_timeout_value,
  output logic lowTimeout,
  output logic highTimeout
);

  logic [5:0] preCnt;
  logic [15:0] lowCnt;
  logic [15:0] highCnt;
  logic lowFired;

  // Count rate: bus/64 or every cycle
  wire tick = timeout_clock_select ? (preCnt == PRESCALE_LAST) : 1'b1;
  wire lowArmed = (low_timeout_value != LOW_VALUE_OFF);
  wire lowHit = ~sclHigh & lowArmed & ~lowFired & (lowCnt >= low_timeout_value);
  wire [15:0] highLimit = low_timeout_value >> HIGH_DIV_SHIFT;

  // Free-running prescaler
  always_ff @(posedge mclk) begin
    if (!rstn) preCnt <= 6'h00;
    else preCnt <= preCnt + 6'h01;
  end

  // Low counter restarts whenever SCL is high
  always_ff @(posedge mclk) begin
    if (!rstn || sclHigh) begin
      lowCnt <= LOW_VALUE_OFF;
      lowFired <= 1'b0;
    end else begin
      if (tick && !(&lowCnt)) lowCnt <= lowCnt + 16'h0001;
      if (lowHit) lowFired <= 1'b1;
    end
  end

  // High counter runs while both lines are high
  always_ff @(posedge mclk) begin
    if (!rstn || !busHigh) highCnt <= LOW_VALUE_OFF;
    else if (tick && !(&highCnt)) highCnt <= highCnt + 16'h0001;
  end

  // Outputs: one pulse per low stretch, level for bus free
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lowTimeout <= 1'b0;
      highTimeout <= 1'b0;
    end else begin
      lowTimeout <= lowHit;
      highTimeout <= busHigh & (highCnt > highLimit);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_zero_off: assert property (low_timeout_value == LOW_VALUE_OFF |=> !lowTimeout)
    else $error("Low timeout fired with zero timeout value");
  a_low_restart: assert property (sclHigh |=> lowCnt == LOW_VALUE_OFF)
    else $error("Low counter not restarted while SCL high");
  a_high_clear: assert property (!busHigh |=> !highTimeout)
    else $error("High timeout flag held while bus not idle");
  a_prescale_gap: assert property (timeout_clock_select && tick ##1 timeout_clock_select |-> !tick)
    else $error("Divided count rate ticked twice in a row");

endmodule : isx_timeout

// File: src/isx_ext_ctrl.sv
// SMBus and addressing extension of the two-wire bus controller
// ----------------------------------------------------------------
// Overview of operation
// - Control bit 7 turns general call address recognition on or off.
// - Control bit 6 selects 7-bit or 10-bit slave addressing.
// - Control bits 2..0 give the top three address bits in 10-bit mode.
// - Fast ack off: stored ack value used; on: software writes ack per byte.
// - SMBus bit 6 enables matching of the alert response address.
// - SMBus bit 5 enables matching of the second slave address.
// - SMBus bit 4 picks timeout count rate: bus/64 or bus clock.
// - Low timeout flag sets on SCL low past nonzero value; write one clears.
// - A zero low-timeout value disables SCL low detection entirely.
// - High timeout flag: both lines high past value/512 counts; clears itself.
// - Low-timeout value is high byte register over low byte register.
// - Second address register bits 7..1 hold the address; bit 0 unused.
// - SDA and SCL are only ever pulled low, never driven high.
// - A transfer runs START, address, data, then STOP.
// - Transfer flag rises on address match, data byte and low timeout events.
// - In fast ack mode the data byte interrupt precedes the ack bit.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module isx_ext_ctrl
  import isx_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [3:0] wbSel,
  output logic [31:0] wbDatR,
  output logic wbAck,
  output logic irq,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  isx_state_type state;
  isx_state_type nextState;
  isx_state_type afterAck;
  isx_state_type next_afterAck;
  logic [1:0] lineSync;
  logic sclPrev;
  logic sdaPrev;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg;
  logic ackLow;
  logic next_ackLow;
  logic pendByte;
  logic next_pendByte;
  logic matchEvt;
  logic byteEvt;
  logic [7:0] extCtrl;
  logic [3:0] smbCfg;
  logic scl_low_timeout_flag;
  logic [6:0] secondAddr;
  logic [7:0] sltHigh;
  logic [7:0] sltLow;
  logic [6:0] ownAddr;
  logic transmit_ack_value;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;
  logic [7:0] rxData;
  logic [7:0] rdData;
  logic lowTimeout;
  logic highTimeout;
  logic highPrev;

  // ----------------------------------------------------------------
  // Bus line sampling and condition detection
  // ----------------------------------------------------------------
  isx_sync u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pinIn({sclIn, sdaIn}),
    .pinOut(lineSync)
  );

  wire sclS = lineSync[1];
  wire sdaS = lineSync[0];

  // Previous line levels for edge detection
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  // Start and stop are SDA edges while SCL stays high
  wire startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopCond = sclS & sclPrev & ~sdaPrev & sdaS;
  wire sclRise = sclS & ~sclPrev;
  wire sclFall = ~sclS & sclPrev;
  wire byteDone = sclFall & (bitCnt == BITS_PER_BYTE);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire busReq = wbCyc & wbStb & ~wbAck;
  wire wrEn = busReq & wbWe & wbSel[0];
  wire [7:0] wd = wbDatW[7:0];
  wire wrExt = wrEn & (wbAdr == EXT_CTRL_OFS);
  wire wrSmb = wrEn & (wbAdr == SMB_CS_OFS);
  wire wrSecond = wrEn & (wbAdr == SECOND_ADDR_OFS);
  wire wrSltHigh = wrEn & (wbAdr == SLT_HIGH_OFS);
  wire wrSltLow = wrEn & (wbAdr == SLT_LOW_OFS);
  wire wrOwn = wrEn & (wbAdr == OWN_ADDR_OFS);
  wire wrAck = wrEn & (wbAdr == ACK_CTRL_OFS);
  wire wrIrqStat = wrEn & (wbAdr == IRQ_STAT_OFS);
  wire wrIrqMask = wrEn & (wbAdr == IRQ_MASK_OFS);

  // Control fields
  wire gcEn = extCtrl[GEN_CALL_BIT];
  wire tenBit = extCtrl[ADDR_EXT_BIT];
  wire [2:0] upper = extCtrl[UPPER_MSB:0];
  wire fastAck = smbCfg[FAST_ACK_BIT - 4];
  wire alert_address_enable = smbCfg[ALERT_EN_BIT - 4];
  wire secondEn = smbCfg[SECOND_EN_BIT - 4];
  wire timeout_clock_select = smbCfg[TCK_SEL_BIT - 4];
  wire [15:0] low_timeout_value = {sltHigh, sltLow};

  // ----------------------------------------------------------------
  // Address matching
  // ----------------------------------------------------------------
  wire [6:0] callAddr = shiftReg[7:1];
  wire hitOwn = ~tenBit & (callAddr == ownAddr);
  wire hitGen = gcEn & (shiftReg == GEN_CALL_ADDR);
  wire hitAlert = alert_address_enable & (callAddr == ALERT_ADDR);
  wire hitSecond = secondEn & (callAddr == secondAddr);
  wire hitTenHi = tenBit & (shiftReg[7:3] == TEN_BIT_TAG) & (shiftReg[2:1] == upper[2:1]) & ~shiftReg[0];
  wire hitTenLo = (shiftReg == {upper[0], ownAddr});
  wire hitSeven = hitOwn | hitGen | hitAlert | hitSecond;

  // ----------------------------------------------------------------
  // Receive sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nextState = state;
    next_ackLow = ackLow;
    next_afterAck = afterAck;
    next_pendByte = pendByte;
    matchEvt = 1'b0;
    byteEvt = 1'b0;
    if (stopCond) begin
      nextState = ST_IDLE;
      next_ackLow = 1'b0;
      next_pendByte = 1'b0;
    end else if (startCond) begin
      nextState = ST_ADDR;
      next_ackLow = 1'b0;
      next_pendByte = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_SKIP: begin
          nextState = state;
        end
        ST_ADDR: begin
          if (byteDone) begin
            if (hitTenHi) begin
              nextState = ST_ACK;
              next_ackLow = 1'b1;
              next_afterAck = ST_ADDR2;
            end else if (hitSeven) begin
              nextState = ST_ACK;
              next_ackLow = 1'b1;
              next_afterAck = shiftReg[0] ? ST_SKIP : ST_DATA;
              matchEvt = 1'b1;
            end else begin
              nextState = ST_SKIP;
            end
          end
        end
        ST_ADDR2: begin
          if (byteDone) begin
            if (hitTenLo) begin
              nextState = ST_ACK;
              next_ackLow = 1'b1;
              next_afterAck = ST_DATA;
              matchEvt = 1'b1;
            end else begin
              nextState = ST_SKIP;
            end
          end
        end
        ST_DATA: begin
          if (byteDone) begin
            if (fastAck) begin
              nextState = ST_HOLD;
              byteEvt = 1'b1;
            end else begin
              nextState = ST_ACK;
              next_ackLow = ~transmit_ack_value;
              next_afterAck = ST_DATA;
              next_pendByte = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (wrAck) begin
            nextState = ST_ACK;
            next_ackLow = ~wd[0];
            next_afterAck = ST_DATA;
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            nextState = afterAck;
            next_ackLow = 1'b0;
            next_pendByte = 1'b0;
            byteEvt = pendByte;
          end
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      afterAck <= ST_IDLE;
      ackLow <= 1'b0;
      pendByte <= 1'b0;
    end else begin
      state <= nextState;
      afterAck <= next_afterAck;
      ackLow <= next_ackLow;
      pendByte <= next_pendByte;
    end
  end

  // Bit counter and shifter, MSB first on SCL rise
  wire shiftState = (state == ST_ADDR) | (state == ST_ADDR2) | (state == ST_DATA);
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bitCnt <= 4'h0;
      shiftReg <= BYTE_RST;
    end else if (startCond || (state == ST_ACK && sclFall)) begin
      bitCnt <= 4'h0;
    end else if (shiftState && sclRise) begin
      bitCnt <= bitCnt + 4'h1;
      shiftReg <= {shiftReg[6:0], sdaS};
    end
  end

  // Open-drain drive: ack pulls SDA, fast ack hold stretches SCL
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
    end else begin
      sdaOe <= (nextState == ST_ACK) & next_ackLow;
      sclOe <= (nextState == ST_HOLD);
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Timeouts
  // ----------------------------------------------------------------
  isx_timeout u_timeout (
    .mclk(mclk),
    .rstn(rstn),
    .sclHigh(sclS),
    .busHigh(sclS & sdaS),
    .timeout_clock_select(timeout_clock_select),
    .low_timeout_value(low_timeout_value),
    .lowTimeout(lowTimeout),
    .highTimeout(highTimeout)
  );

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      extCtrl <= EXT_CTRL_RST;
      smbCfg <= SMB_CFG_RST;
      secondAddr <= ADDR7_RST;
      sltHigh <= BYTE_RST;
      sltLow <= BYTE_RST;
      ownAddr <= ADDR7_RST;
      transmit_ack_value <= 1'b0;
      irqMask <= IRQ_RST;
    end else begin
      if (wrExt) extCtrl <= wd & EXT_CTRL_MASK;
      if (wrSmb) smbCfg <= wd[7:4];
      if (wrSecond) secondAddr <= wd[7:1];
      if (wrSltHigh) sltHigh <= wd;
      if (wrSltLow) sltLow <= wd;
      if (wrOwn) ownAddr <= wd[6:0];
      if (wrAck) transmit_ack_value <= wd[0];
      if (wrIrqMask) irqMask <= wd[3:0];
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  wire [3:0] irqSet = {highTimeout & ~highPrev, lowTimeout, byteEvt, matchEvt};
  wire [3:0] irqClr = wrIrqStat ? wd[3:0] : IRQ_RST;
  wire sltfClr = wrSmb & wd[LOW_TO_BIT];
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqStatus <= IRQ_RST;
      scl_low_timeout_flag <= 1'b0;
      highPrev <= 1'b0;
      irq <= 1'b0;
    end else begin
      irqStatus <= (irqStatus & ~irqClr) | irqSet;
      scl_low_timeout_flag <= (scl_low_timeout_flag & ~sltfClr) | lowTimeout;
      highPrev <= highTimeout;
      irq <= |(irqStatus & irqMask);
    end
  end

  // Last received data byte
  always_ff @(posedge mclk) begin
    if (!rstn) rxData <= BYTE_RST;
    else if (state == ST_DATA && byteDone) rxData <= shiftReg;
  end

  // ----------------------------------------------------------------
  // Read path and bus answer
  // ----------------------------------------------------------------
  wire xferFlag = |irqStatus[IRQ_LOW:IRQ_MATCH];
  always_comb begin
    unique case (wbAdr)
      EXT_CTRL_OFS: rdData = extCtrl;
      SMB_CS_OFS: rdData = {smbCfg, scl_low_timeout_flag, highTimeout, 2'b00};
      SECOND_ADDR_OFS: rdData = {secondAddr, 1'b0};
      SLT_HIGH_OFS: rdData = sltHigh;
      SLT_LOW_OFS: rdData = sltLow;
      OWN_ADDR_OFS: rdData = {1'b0, ownAddr};
      ACK_CTRL_OFS: rdData = {7'h00, transmit_ack_value};
      IRQ_STAT_OFS: rdData = {xferFlag, 3'h0, irqStatus};
      IRQ_MASK_OFS: rdData = {4'h0, irqMask};
      RX_DATA_OFS: rdData = rxData;
      default: rdData = BYTE_RST;
    endcase
  end

  // Answer one cycle after the request is seen
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wbAck <= 1'b0;
      wbDatR <= 32'h0000_0000;
    end else begin
      wbAck <= busReq;
      wbDatR <= {24'h00_0000, rdData};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_req;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence s_ack_once;
    wbAck ##1 !wbAck;
  endsequence
  sequence s_fast_byte;
    state == ST_DATA && byteDone && fastAck && !stopCond && !startCond;
  endsequence

  a_bus_answer: assert property (s_req |=> s_ack_once)
    else $error("Bus request not answered in one cycle");
  a_scl_low_timeout_flag_sticky: assert property (lowTimeout |=> scl_low_timeout_flag)
    else $error("Low timeout did not set its flag");
  a_fast_irq: assert property (s_fast_byte |=> state == ST_HOLD && irqStatus[IRQ_BYTE] && sclOe)
    else $error("Fast ack byte interrupt not raised before ack");
  a_transmit_ack_value_drive: assert property (state == ST_HOLD && wrAck && !stopCond && !startCond
    |=> sdaOe == !$past(wbDatW[0]))
    else $error("Ack drive does not follow written ack value");
  a_open_drain: assert property (!sdaOut && !sclOut)
    else $error("Bus line driven high");
  a_gen_call_off: assert property (state == ST_ADDR && byteDone && !startCond && !stopCond && !gcEn
    && shiftReg == GEN_CALL_ADDR && !hitOwn && !hitAlert && !hitSecond |=> state == ST_SKIP && !sdaOe)
    else $error("General call acknowledged while disabled");
  a_irq_level: assert property (1'b1 |=> irq == $past(|(irqStatus & irqMask)))
    else $error("Interrupt output does not follow masked status");

endmodule : isx_ext_ctrl

// File: sim/isx_i2c_master.sv
// Two-wire bus master model that only ever pulls the lines low
`timescale 1ns/1ps
module isx_i2c_master (
  input wire logic mclk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclLow,
  output logic sdaLow
);
  localparam int HALF = 20;
  // Released lines rise through the pull-up
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask : hold
  // Release SCL, wait out any stretch, sample SDA mid-high
  task automatic clkPulse(output logic seen);
    int t;
    t = 0;
    sclLow <= 1'b0;
    hold(1);
    while (sclIn !== 1'b1 && t < 4000) begin
      hold(1);
      t++;
    end
    hold(HALF / 2);
    seen = sdaIn;
    hold(HALF / 2);
    sclLow <= 1'b1;
  endtask : clkPulse
  task automatic busStart();
    sdaLow <= 1'b1;
    hold(HALF);
    sclLow <= 1'b1;
    hold(HALF);
  endtask : busStart
  // Eight bits MSB first, then the ack clock; ack is 1 when SDA was low
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sdaLow <= ~b[i];
      hold(HALF);
      clkPulse(s);
    end
    sdaLow <= 1'b0;
    hold(HALF);
    clkPulse(s);
    ack = ~s;
  endtask : sendByte
  task automatic busStop();
    sdaLow <= 1'b1;
    hold(HALF);
    sclLow <= 1'b0;
    hold(HALF);
    sdaLow <= 1'b0;
    hold(HALF);
  endtask : busStop
  task automatic holdSclLow(input int n);
    sclLow <= 1'b1;
    hold(n);
    sclLow <= 1'b0;
    hold(HALF);
  endtask : holdSclLow
endmodule : isx_i2c_master

// File: sim/tb_isx_ext_ctrl.sv
// Self-checking bench for the SMBus extension block
`timescale 1ns/1ps
module tb_isx_ext_ctrl import isx_pkg::*;;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0000_0000;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatR;
  logic wbAck, irq, sdaOut, sdaOe, sclOut, sclOe, sclLow, sdaLow, scl, sda, ack;
  int errors = 0;
  int numChecks = 0;
  // Wired-AND of both parties with pull-ups
  assign scl = ~(sclOe | sclLow);
  assign sda = ~(sdaOe | sdaLow);
  always #4 mclk = ~mclk;
  isx_ext_ctrl i_isx_ext_ctrl (.mclk(mclk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbDatW(wbDatW), .wbSel(wbSel), .wbDatR(wbDatR), .wbAck(wbAck), .irq(irq),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe));
  isx_i2c_master i_isx_i2c_master (.mclk(mclk), .sclIn(scl), .sdaIn(sda), .sclLow(sclLow), .sdaLow(sdaLow));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // Classic single cycle, held until ack is sampled
  task automatic busXfer(input logic we, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel,
    output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= {24'h00_0000, dat};
    wbSel <= sel;
    do begin
      @(posedge mclk);
      t++;
    end while (wbAck !== 1'b1 && t < 50);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (t >= 50) check("wbAck", 32'h0000_0001, 32'h0000_0000);
  endtask : busXfer
  // A write without byte lane 0 must leave the register alone
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel = 4'hF);
    logic [31:0] d;
    busXfer(1'b1, adr, dat, sel, d);
  endtask : wr
  task automatic rdChk(input string nm, input logic [7:0] adr, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    busXfer(1'b0, adr, 8'h00, 4'hF, d);
    check(nm, exp, d & m);
  endtask : rdChk
  task automatic irqChk(input logic exp);
    repeat (3) @(posedge mclk);
    check("irq", {31'h0000_0000, exp}, {31'h0000_0000, irq});
  endtask : irqChk
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testRegs();
    rdChk("extRst", EXT_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk("unmapped", 8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
    check("pins", 32'h0000_0000, {30'h0000_0000, sdaOut, sclOut});
    wr(EXT_CTRL_OFS, 8'hFF);
    rdChk("extMask", EXT_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_00C7);
    wr(SECOND_ADDR_OFS, 8'hFF);
    rdChk("second", SECOND_ADDR_OFS, 32'hFFFF_FFFF, 32'h0000_00FE);
    wr(SLT_HIGH_OFS, 8'h12);
    wr(SLT_LOW_OFS, 8'h34);
    wr(SLT_LOW_OFS, 8'hAA, 4'hE);
    rdChk("sltHigh", SLT_HIGH_OFS, 32'hFFFF_FFFF, 32'h0000_0012);
    rdChk("sltLow", SLT_LOW_OFS, 32'hFFFF_FFFF, 32'h0000_0034);
    $display("test registers done");
  endtask : testRegs
  // Each entry: control, smbus config, address byte, ack expected
  task automatic testAddr();
    logic [24:0] cs [8] = '{{16'h0000, 8'h54, 1'b1}, {16'h0000, 8'h56, 1'b0}, {16'h0000, 8'h00, 1'b0},
      {16'h8000, 8'h00, 1'b1}, {16'h0000, 8'h18, 1'b0}, {16'h0040, 8'h18, 1'b1}, {16'h0000, 8'h66, 1'b0},
      {16'h0020, 8'h66, 1'b1}};
    wr(OWN_ADDR_OFS, 8'h2A);
    wr(SECOND_ADDR_OFS, 8'h66);
    for (int i = 0; i < 8; i++) begin
      wr(EXT_CTRL_OFS, cs[i][24:17]);
      wr(SMB_CS_OFS, cs[i][16:9]);
      wr(IRQ_STAT_OFS, 8'hFF);
      i_isx_i2c_master.busStart();
      i_isx_i2c_master.sendByte(cs[i][8:1], ack);
      i_isx_i2c_master.busStop();
      check("addrAck", {31'h0000_0000, cs[i][0]}, {31'h0000_0000, ack});
      rdChk("match", IRQ_STAT_OFS, 32'h0000_0081, {24'h00_0000, cs[i][0], 6'h00, cs[i][0]});
    end
    wr(EXT_CTRL_OFS, 8'h45);
    i_isx_i2c_master.busStart();
    i_isx_i2c_master.sendByte(8'hF4, ack);
    check("tenFirst", 32'h0000_0001, {31'h0000_0000, ack});
    i_isx_i2c_master.sendByte(8'hAA, ack);
    i_isx_i2c_master.busStop();
    check("tenSecond", 32'h0000_0001, {31'h0000_0000, ack});
    wr(EXT_CTRL_OFS, 8'h00);
    $display("test addressing done");
  endtask : testAddr
  // Fast ack off uses stored value; on, software answers during the stretch
  task automatic testAck(input logic fast);
    int t;
    wr(SMB_CS_OFS, {fast, 7'h00});
    for (int v = 0; v < 2; v++) begin
      wr(IRQ_STAT_OFS, 8'hFF);
      if (!fast) wr(ACK_CTRL_OFS, v[7:0]);
      i_isx_i2c_master.busStart();
      i_isx_i2c_master.sendByte(8'h54, ack);
      fork
        i_isx_i2c_master.sendByte(8'hA5 ^ v[7:0], ack);
        if (fast) begin
          t = 0;
          while (sclOe !== 1'b1 && t < 2000) begin
            @(posedge mclk);
            t++;
          end
          rdChk("byteEarly", IRQ_STAT_OFS, 32'h0000_0002, 32'h0000_0002);
          wr(ACK_CTRL_OFS, v[7:0]);
        end
      join
      i_isx_i2c_master.busStop();
      check("dataAck", {31'h0000_0000, v == 0}, {31'h0000_0000, ack});
      rdChk("rxData", RX_DATA_OFS, 32'hFFFF_FFFF, {24'h00_0000, 8'hA5 ^ v[7:0]});
      rdChk("byteIrq", IRQ_STAT_OFS, 32'h0000_0002, 32'h0000_0002);
    end
    $display("test ack done");
  endtask : testAck
  task automatic testTimeout();
    wr(SMB_CS_OFS, 8'h00);
    wr(SLT_HIGH_OFS, 8'h00);
    wr(SLT_LOW_OFS, 8'h00);
    wr(IRQ_MASK_OFS, 8'h04);
    wr(IRQ_STAT_OFS, 8'hFF);
    i_isx_i2c_master.holdSclLow(300);
    rdChk("lowOff", SMB_CS_OFS, 32'h0000_0008, 32'h0000_0000);
    irqChk(1'b0);
    wr(SLT_LOW_OFS, 8'h40);
    i_isx_i2c_master.holdSclLow(50);
    i_isx_i2c_master.holdSclLow(50);
    rdChk("lowRestart", SMB_CS_OFS, 32'h0000_0008, 32'h0000_0000);
    i_isx_i2c_master.holdSclLow(300);
    rdChk("lowSet", SMB_CS_OFS, 32'h0000_0008, 32'h0000_0008);
    rdChk("lowStat", IRQ_STAT_OFS, 32'h0000_0084, 32'h0000_0084);
    irqChk(1'b1);
    wr(SMB_CS_OFS, 8'h08);
    rdChk("lowClr", SMB_CS_OFS, 32'h0000_0008, 32'h0000_0000);
    wr(IRQ_MASK_OFS, 8'h00);
    irqChk(1'b0);
    wr(IRQ_MASK_OFS, 8'h04);
    wr(IRQ_STAT_OFS, 8'hFF);
    irqChk(1'b0);
    wr(SMB_CS_OFS, 8'h10);
    i_isx_i2c_master.holdSclLow(300);
    rdChk("slowTick", SMB_CS_OFS, 32'h0000_0008, 32'h0000_0000);
    // High flag is also judged at the divided rate
    wr(SMB_CS_OFS, 8'h10);
    wr(SLT_HIGH_OFS, 8'h04);
    wr(SLT_LOW_OFS, 8'h00);
    i_isx_i2c_master.holdSclLow(10);
    rdChk("highEarly", SMB_CS_OFS, 32'h0000_0004, 32'h0000_0000);
    repeat (300) @(posedge mclk);
    rdChk("highSet", SMB_CS_OFS, 32'h0000_0004, 32'h0000_0004);
    rdChk("highStat", IRQ_STAT_OFS, 32'h0000_0088, 32'h0000_0008);
    fork
      i_isx_i2c_master.holdSclLow(100);
      begin
        repeat (40) @(posedge mclk);
        rdChk("highClr", SMB_CS_OFS, 32'h0000_0004, 32'h0000_0000);
      end
    join
    $display("test timeouts done");
  endtask : testTimeout
  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : endOfTest
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (10) @(posedge mclk);
    testRegs();
    testAddr();
    testAck(1'b0);
    testAck(1'b1);
    testTimeout();
    endOfTest();
  end
  // Cuts a hang short
  initial begin
    repeat (90000) @(posedge mclk);
    errors++;
    endOfTest();
  end
endmodule : tb_isx_ext_ctrl
